// ### atr_channel.sv
`timescale 1ns/10ps
module atr_channel
    import atr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic load_duty,
    input wire logic [11:0] count,
    input wire logic [11:0] duty_pre,
    input wire logic oe,
    input wire logic invert,
    input wire logic brk,
    input wire logic pattern,
    input wire logic clr_flag,
    output logic pwm,
    output logic flag
);
    typedef struct packed {
        logic [11:0] duty_act;
        logic pwm;
        logic flag;
    } ch_state_t;

    ch_state_t s_q;
    ch_state_t s_d;
    logic raw;

    // active duty only moves at overflow so a period never tears
    always_comb begin
        s_d = s_q;
        raw = count < s_q.duty_act;
        if (load_duty) begin
            s_d.duty_act = duty_pre;
        end
        if (clr_flag) begin
            s_d.flag = 1'b0;
        end
        if (step && count == s_q.duty_act) begin
            s_d.flag = 1'b1;
        end
        if (!oe) begin
            s_d.pwm = 1'b0;
        end else if (brk) begin
            s_d.pwm = pattern;
        end else begin
            s_d.pwm = raw ^ invert;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pwm = s_q.pwm;
    assign flag = s_q.flag;

    chk_break_pattern: assert property (@(posedge clk) disable iff (!rst_n)
        oe && brk |=> pwm == $past(pattern))
        else $error("break did not force the pattern level");
    chk_compare_flag: assert property (@(posedge clk) disable iff (!rst_n)
        step && count == s_q.duty_act |=> flag)
        else $error("compare match did not set the flag");
    cov_break: cover property (@(posedge clk) disable iff (!rst_n)
        oe && brk);
endmodule

// ### atr_counter.sv
`timescale 1ns/10ps
module atr_counter
    import atr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic force_load,
    input wire logic restart,
    input wire logic [11:0] reload,
    output logic [11:0] count,
    output logic ovf,
    output logic step
);
    typedef struct packed {
        logic [11:0] count;
        logic ovf;
        logic step;
    } cnt_state_t;

    cnt_state_t s_q;
    cnt_state_t s_d;

    // restart beats force, force beats a normal tick
    always_comb begin
        s_d = s_q;
        s_d.ovf = 1'b0;
        s_d.step = 1'b0;
        if (restart) begin
            s_d.count = CNT_RST;
            s_d.step = 1'b1;
        end else if (force_load) begin
            s_d.count = CNT_MAX;
        end else if (tick) begin
            s_d.step = 1'b1;
            if (s_q.count == CNT_MAX) begin
                s_d.count = reload;
                s_d.ovf = 1'b1;
            end else begin
                s_d.count = s_q.count + 12'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.count;
    assign ovf = s_q.ovf;
    assign step = s_q.step;

    chk_force_loads_max: assert property (@(posedge clk) disable iff (!rst_n)
        force_load && !restart |=> count == CNT_MAX)
        else $error("forced overflow did not load the maximum count");
    chk_reload_on_ovf: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !force_load && !restart && count == CNT_MAX
        |=> ovf && count == $past(reload))
        else $error("counter did not restart from its reload value");
    cov_wrap: cover property (@(posedge clk) disable iff (!rst_n) ovf);
endmodule

// ### atr_pkg.sv
package atr_pkg;
    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IX_TCS = 6'h00;
    localparam logic [5:0] IX_CNT1_HI = 6'h01;
    localparam logic [5:0] IX_CNT1_LO = 6'h02;
    localparam logic [5:0] IX_RLD1_HI = 6'h03;
    localparam logic [5:0] IX_RLD1_LO = 6'h04;
    localparam logic [5:0] IX_PWM_OE = 6'h05;
    localparam logic [5:0] IX_CSR0 = 6'h06;
    localparam logic [5:0] IX_BRK = 6'h0A;
    localparam logic [5:0] IX_TCS2 = 6'h0B;
    localparam logic [5:0] IX_RLD2_HI = 6'h0C;
    localparam logic [5:0] IX_RLD2_LO = 6'h0D;
    localparam logic [5:0] IX_DUTY0 = 6'h0E;
    localparam logic [5:0] IX_CAP_HI = 6'h16;
    localparam logic [5:0] IX_CAP_LO = 6'h17;
    localparam logic [5:0] IX_LAST = 6'h17;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int B_CAPF = 6;
    localparam int B_CAPIE = 5;
    localparam int B_CKHI = 4;
    localparam int B_CKLO = 3;
    localparam int B_OVERFLOW_FLAG_ONE = 2;
    localparam int B_OVERFLOW_IRQ_ENABLE_ONE = 1;
    localparam int B_COMPARE_IRQ_ENABLE = 0;
    localparam int B_FORCE_OVERFLOW_COUNTER_TWO = 7;
    localparam int B_FORCE_OVERFLOW_COUNTER_ONE = 6;
    localparam int B_OVFIE2 = 4;
    localparam int B_OVF2 = 3;
    localparam int B_ENCNT2 = 2;
    localparam int B_OPEN = 3;
    localparam int B_ONE_PULSE_TRIGGER_EDGE = 2;
    localparam int B_INV = 1;
    localparam int B_CMPF = 0;
    localparam int B_BREAK_SOURCE_SELECT = 7;
    localparam int B_BRLVL = 6;
    localparam int B_BRACT = 5;
    localparam int B_BREAK_PIN_ENABLE = 4;
    localparam int OP_CH = 3;
    // ****************************************************************
    // values
    // ****************************************************************
    localparam logic [11:0] CNT_MAX = 12'hFFF;
    localparam logic [11:0] CNT_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] CK_OFF = 2'h0;
    localparam logic [1:0] CK_LITE = 2'h1;
    localparam logic [1:0] CK_CPU = 2'h2;
    localparam logic [1:0] CK_FAST = 2'h3;
endpackage

// ### autoreload_pwm_timer_control.sv
// What this block does
// - setting a force-overflow bit loads that counter with FFFh
// - after overflow a counter restarts from its own reload value
// - hardware clears a force-overflow bit once its overflow happened
// - timer runs during wait, stops during halt
// - compare and capture events share one interrupt line
// - overflow events have their own interrupt line
// - interrupt needs flag, enable, and global mask cleared
// - capture flag bit 6 set on capture, cleared by capture reads
// - clock select bits 4:3: off, lite tick, cpu, fast tick
// - overflow flag one set on wrap, cleared by status read
// - compare enable bit 0 gates the compare interrupt
// - counter one is a read-only 12-bit up-counter
// - clear output enable frees the pin, set enables pwm
// - one-pulse enable bit 3 of channel 3 control
// - trigger edge bit 2: 0 falling, 1 rising, one-pulse only
// - polarity bit 1 inverts the pwm signal
// - compare flag bit 0 set on match, cleared by its read
// - break source bit 7: pin or comparator
// - break level bit 6: low or high is active
// - break-active bit 5 software r/w, hardware sets it
// - during break enabled outputs show their pattern bit
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module autoreload_pwm_timer_control
    import atr_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic LITE_TICK,
    input wire logic FAST_TICK,
    input wire logic HALT_MODE,
    input wire logic IRQ_MASK,
    input wire logic CAPTURE_EVT,
    input wire logic TRIG_IN,
    input wire logic BREAK_PIN,
    input wire logic COMP_OUT,
    output logic [3:0] PWM_OUT,
    output logic [3:0] PWM_OE,
    output logic IRQ_OVF,
    output logic IRQ_CMP_CAP
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic cap_flag;
        logic cap_ie;
        logic [1:0] src_sel;
        logic overflow_flag_one;
        logic ovf_ie1;
        logic cmp_ie;
        logic force_overflow_counter_two;
        logic force_overflow_counter_one;
        logic ovf_ie2;
        logic ovf2;
        logic en_cnt2;
        logic fp1;
        logic fp2;
        logic [11:0] reload1;
        logic [11:0] reload2;
        logic [3:0] oe;
        logic [3:0] inv;
        logic one_pulse_enable;
        logic op_edge;
        logic [3:0][11:0] duty;
        logic [11:0] cap;
        logic [7:0] brk;
        logic trig_prev;
        logic irq_ovf;
        logic irq_cc;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [11:0] cnt1;
    logic [11:0] cnt2;
    logic overflow_flag_one_evt;
    logic ovf2_evt;
    logic step1;
    logic step2;
    logic tick;
    logic req;
    logic wr;
    logic rd;
    logic [5:0] idx;
    logic [5:0] doff;
    logic [7:0] wb;
    logic [3:0] cmpf;
    logic [3:0] pwm;
    logic [3:0] csr_rd;
    logic trig_edge;
    logic restart2;
    logic brk_src;
    logic brk_hit;

    // ****************************************************************
    // counter clock and one-pulse trigger
    // ****************************************************************
    // halt freezes both counters; wait has no port since it changes nothing
    always_comb begin
        case (s_q.src_sel)
            CK_LITE: tick = LITE_TICK;
            CK_CPU: tick = 1'b1;
            CK_FAST: tick = FAST_TICK;
            default: tick = 1'b0;
        endcase
        if (HALT_MODE) begin
            tick = 1'b0;
        end
    end

    // edge select only matters while one-pulse mode is on
    assign trig_edge = s_q.op_edge ? (TRIG_IN & ~s_q.trig_prev)
                                   : (~TRIG_IN & s_q.trig_prev);
    assign restart2 = s_q.one_pulse_enable & s_q.en_cnt2 & trig_edge & ~HALT_MODE;

    atr_counter u_cnt1 (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .tick(tick),
        .force_load(s_q.fp1),
        .restart(1'b0),
        .reload(s_q.reload1),
        .count(cnt1),
        .ovf(overflow_flag_one_evt),
        .step(step1)
    );

    atr_counter u_cnt2 (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .tick(tick & s_q.en_cnt2),
        .force_load(s_q.fp2),
        .restart(restart2),
        .reload(s_q.reload2),
        .count(cnt2),
        .ovf(ovf2_evt),
        .step(step2)
    );

    // ****************************************************************
    // break detection
    // ****************************************************************
    assign brk_src = s_q.brk[B_BREAK_SOURCE_SELECT] ? COMP_OUT : BREAK_PIN;
    assign brk_hit = s_q.brk[B_BREAK_PIN_ENABLE]
                   & (brk_src == s_q.brk[B_BRLVL]);

    // ****************************************************************
    // pwm channels; 2 and 3 follow counter two when it is enabled
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            logic use2;
            assign use2 = (g >= 2) && s_q.en_cnt2;
            atr_channel u_ch (
                .clk(CLK_SYS),
                .rst_n(RST_N),
                .step(use2 ? step2 : step1),
                .load_duty(use2 ? ovf2_evt : overflow_flag_one_evt),
                .count(use2 ? cnt2 : cnt1),
                .duty_pre(s_q.duty[g]),
                .oe(s_q.oe[g]),
                .invert(s_q.inv[g]),
                .brk(s_q.brk[B_BRACT]),
                .pattern(s_q.brk[g]),
                .clr_flag(csr_rd[g]),
                .pwm(pwm[g]),
                .flag(cmpf[g])
            );
            assign csr_rd[g] = rd && idx == IX_CSR0 + 6'(g);
        end
    endgenerate

    // ****************************************************************
    // wishbone decode
    // ****************************************************************
    // one access per request; ack drops for a cycle before the next
    assign req = CYC_I & STB_I & ~s_q.ack;
    assign idx = ADR_I[7:2];
    assign wr = req & WE_I & SEL_I[0];
    assign rd = req & ~WE_I;
    assign wb = DAT_I[7:0];
    assign doff = idx - IX_DUTY0;

    // ****************************************************************
    // register file, flags and interrupt lines
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.fp1 = 1'b0;
        s_d.fp2 = 1'b0;
        s_d.trig_prev = TRIG_IN;
        // read mux; unmapped and reserved bits read zero
        if (rd) begin
            case (idx)
                IX_TCS: s_d.rdat = {1'b0, s_q.cap_flag, s_q.cap_ie,
                    s_q.src_sel, s_q.overflow_flag_one, s_q.ovf_ie1, s_q.cmp_ie};
                IX_CNT1_HI: s_d.rdat = {4'h0, cnt1[11:8]};
                IX_CNT1_LO: s_d.rdat = cnt1[7:0];
                IX_RLD1_HI: s_d.rdat = {4'h0, s_q.reload1[11:8]};
                IX_RLD1_LO: s_d.rdat = s_q.reload1[7:0];
                IX_PWM_OE: s_d.rdat = {1'b0, s_q.oe[3], 1'b0, s_q.oe[2],
                    1'b0, s_q.oe[1], 1'b0, s_q.oe[0]};
                IX_BRK: s_d.rdat = s_q.brk;
                IX_TCS2: s_d.rdat = {s_q.force_overflow_counter_two, s_q.force_overflow_counter_one, 1'b0,
                    s_q.ovf_ie2, s_q.ovf2, s_q.en_cnt2, 2'h0};
                IX_RLD2_HI: s_d.rdat = {4'h0, s_q.reload2[11:8]};
                IX_RLD2_LO: s_d.rdat = s_q.reload2[7:0];
                IX_CAP_HI: s_d.rdat = {4'h0, s_q.cap[11:8]};
                IX_CAP_LO: s_d.rdat = s_q.cap[7:0];
                default: s_d.rdat = BYTE_RST;
            endcase
            if (idx >= IX_CSR0 && idx < IX_CSR0 + 6'h04) begin
                s_d.rdat = {4'h0,
                    (idx[1:0] == 2'h1) ? {s_q.one_pulse_enable, s_q.op_edge} : 2'h0,
                    s_q.inv[idx[1:0] - 2'h2], cmpf[idx[1:0] - 2'h2]};
            end
            if (idx >= IX_DUTY0 && idx < IX_CAP_HI) begin
                s_d.rdat = doff[0] ? s_q.duty[doff[2:1]][7:0]
                         : {4'h0, s_q.duty[doff[2:1]][11:8]};
            end
            // read side effects clear flags; sets below still win, except a capture while cap_flag is set
            if (idx == IX_TCS) begin
                s_d.overflow_flag_one = 1'b0;
            end
            if (idx == IX_TCS2) begin
                s_d.ovf2 = 1'b0;
            end
            if (idx == IX_CAP_HI || idx == IX_CAP_LO) begin
                s_d.cap_flag = 1'b0;
            end
        end
        // writes; flag bits and reserved bits are not writable
        if (wr) begin
            case (idx)
                IX_TCS: begin
                    s_d.cap_ie = wb[B_CAPIE];
                    s_d.src_sel = wb[B_CKHI:B_CKLO];
                    s_d.ovf_ie1 = wb[B_OVERFLOW_IRQ_ENABLE_ONE];
                    s_d.cmp_ie = wb[B_COMPARE_IRQ_ENABLE];
                end
                IX_RLD1_HI: s_d.reload1[11:8] = wb[3:0];
                IX_RLD1_LO: s_d.reload1[7:0] = wb;
                IX_PWM_OE: s_d.oe = {wb[6], wb[4], wb[2], wb[0]};
                IX_BRK: s_d.brk = wb;
                IX_TCS2: begin
                    // software can only set force bits
                    s_d.force_overflow_counter_one = s_q.force_overflow_counter_one | wb[B_FORCE_OVERFLOW_COUNTER_ONE];
                    s_d.force_overflow_counter_two = s_q.force_overflow_counter_two | wb[B_FORCE_OVERFLOW_COUNTER_TWO];
                    s_d.fp1 = wb[B_FORCE_OVERFLOW_COUNTER_ONE];
                    s_d.fp2 = wb[B_FORCE_OVERFLOW_COUNTER_TWO];
                    s_d.ovf_ie2 = wb[B_OVFIE2];
                    s_d.en_cnt2 = wb[B_ENCNT2];
                end
                IX_RLD2_HI: s_d.reload2[11:8] = wb[3:0];
                IX_RLD2_LO: s_d.reload2[7:0] = wb;
                default: begin
                end
            endcase
            if (idx >= IX_CSR0 && idx < IX_CSR0 + 6'h04) begin
                s_d.inv[idx[1:0] - 2'h2] = wb[B_INV];
                if (idx == IX_CSR0 + 6'(OP_CH)) begin
                    s_d.one_pulse_enable = wb[B_OPEN];
                    s_d.op_edge = wb[B_ONE_PULSE_TRIGGER_EDGE];
                end
            end
            if (idx >= IX_DUTY0 && idx < IX_CAP_HI) begin
                if (doff[0]) begin
                    s_d.duty[doff[2:1]][7:0] = wb;
                end else begin
                    s_d.duty[doff[2:1]][11:8] = wb[3:0];
                end
            end
        end
        // hardware events: set wins over a clear in the same cycle, except a capture, which is ignored while cap_flag is still set
        if (overflow_flag_one_evt) begin
            s_d.overflow_flag_one = 1'b1;
            s_d.force_overflow_counter_one = s_d.fp1;
        end
        if (ovf2_evt) begin
            s_d.ovf2 = 1'b1;
            s_d.force_overflow_counter_two = s_d.fp2;
        end
        if (CAPTURE_EVT && !s_q.cap_flag && !HALT_MODE) begin
            s_d.cap = cnt1;
            s_d.cap_flag = 1'b1;
        end
        if (brk_hit) begin
            s_d.brk[B_BRACT] = 1'b1;
        end
        // separate lines, each gated by the global mask
        s_d.irq_ovf = ~IRQ_MASK & ((s_q.overflow_flag_one & s_q.ovf_ie1)
                    | (s_q.ovf2 & s_q.ovf_ie2));
        s_d.irq_cc = ~IRQ_MASK & ((s_q.cap_flag & s_q.cap_ie)
                   | ((|cmpf) & s_q.cmp_ie));
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ACK_O = s_q.ack;
    assign DAT_O = {24'h000000, s_q.rdat};
    assign IRQ_OVF = s_q.irq_ovf;
    assign IRQ_CMP_CAP = s_q.irq_cc;
    assign PWM_OUT = pwm;
    assign PWM_OE = s_q.oe;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_force_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        overflow_flag_one_evt && !s_d.fp1 |=> !s_q.force_overflow_counter_one)
        else $error("force bit one not cleared after overflow");
    chk_halt_stops: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        HALT_MODE ##1 HALT_MODE |-> $stable(cnt1))
        else $error("counter moved during halt");
    chk_irq_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        IRQ_MASK |=> !IRQ_OVF && !IRQ_CMP_CAP)
        else $error("interrupt raised while globally masked");
    chk_ovf_irq: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !IRQ_MASK && s_q.overflow_flag_one && s_q.ovf_ie1 |=> IRQ_OVF)
        else $error("overflow interrupt missing");
    chk_cmp_irq: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !IRQ_MASK && cmpf[0] && s_q.cmp_ie |=> IRQ_CMP_CAP)
        else $error("compare interrupt missing");
    chk_overflow_flag_one_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        overflow_flag_one_evt |=> s_q.overflow_flag_one)
        else $error("overflow flag one not set");
    chk_cap_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        rd && idx == IX_CAP_LO && !CAPTURE_EVT |=> !s_q.cap_flag)
        else $error("capture read did not clear the flag");
    chk_src_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_q.src_sel == CK_OFF && !s_q.fp1 ##1 s_q.src_sel == CK_OFF
        |-> $stable(cnt1))
        else $error("counter moved with its clock off");
    chk_brk_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        brk_hit |=> s_q.brk[B_BRACT])
        else $error("break level did not set break active");
    cov_ovf_irq: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        IRQ_OVF);
    cov_capture: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        CAPTURE_EVT && !s_q.cap_flag);
    cov_one_pulse: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        restart2);
endmodule

// ### autoreload_pwm_timer_control_tb.sv
`timescale 1ns/10ps
module autoreload_pwm_timer_control_tb
    import atr_pkg::*;
;
    logic clk_sys, rst_n, cyc, stb, we, ack, lite, fast, halt, mask;
    logic cap, trig, bpin, comp, irq_o, irq_c, src, lvl;
    logic [7:0] adr, q;
    logic [3:0] sel, pwm, oe, pat;
    logic [31:0] dat_i, dat_o;
    logic [11:0] r, r1;
    int n_mismatch, checks, ncyc;

    autoreload_pwm_timer_control autoreload_pwm_timer_control_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i),
        .DAT_O(dat_o), .ACK_O(ack), .LITE_TICK(lite), .FAST_TICK(fast),
        .HALT_MODE(halt), .IRQ_MASK(mask), .CAPTURE_EVT(cap),
        .TRIG_IN(trig), .BREAK_PIN(bpin), .COMP_OUT(comp),
        .PWM_OUT(pwm), .PWM_OE(oe), .IRQ_OVF(irq_o), .IRQ_CMP_CAP(irq_c));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one classic cycle; the idle edge at entry keeps requests apart
    task automatic bus(input logic [5:0] ix, input logic w,
                       input logic [7:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {ix, 2'h0};
        dat_i <= {24'h000000, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rdc(input logic [5:0] ix, input logic [7:0] e);
        bus(ix, 1'b0, 8'h00);
        chk(q, e);
    endtask

    // next count after one tick: the maximum wraps to the reload value
    function automatic logic [11:0] nxt(input logic [11:0] c,
                                        input logic [11:0] rl);
        return (c == CNT_MAX) ? rl : c + 12'h001;
    endfunction

    task automatic tick;
        @(posedge clk_sys);
        lite <= 1'b1;
        @(posedge clk_sys);
        lite <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    // selected break source gets a, the other one b
    task automatic brk_in(input logic s, input logic a, input logic b);
        @(posedge clk_sys);
        bpin <= s ? b : a;
        comp <= s ? a : b;
    endtask

    // trigger level change, then two edges for restart and flag
    task automatic trg(input logic v);
        @(posedge clk_sys);
        trig <= v;
        repeat (2) @(posedge clk_sys);
    endtask

    // a hang ends the run through the same report
    always @(posedge clk_sys) begin
        ncyc++;
        if (ncyc == 20000) begin
            n_mismatch++;
            test_done;
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n, cyc, stb, we, lite, fast, halt, cap, trig, comp} = 10'h000;
        {mask, bpin, adr, sel, dat_i} = 46'h0;
        mask = 1'b1;
        void'($urandom(74436));
        r = 12'(1 + $urandom % 4093);
        r1 = r + 12'h001;
        pat = 4'($urandom);
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) rdc(6'(i), 8'h00);
        rdc(6'h20, 8'h00);
        bus(IX_TCS, 1'b1, 8'hFF);
        rdc(IX_TCS, 8'h3B);
        bus(IX_RLD1_HI, 1'b1, {4'hF, r[11:8]});
        rdc(IX_RLD1_HI, {4'h0, r[11:8]});
        bus(IX_RLD1_LO, 1'b1, r[7:0]);
        rdc(IX_RLD1_LO, r[7:0]);
        bus(IX_DUTY0, 1'b1, {4'h0, r1[11:8]});
        bus(IX_DUTY0 + 6'h01, 1'b1, r1[7:0]);
        // lite tick source held still, so the counter only moves on tick
        bus(IX_TCS, 1'b1, 8'h0B);
        bus(IX_TCS2, 1'b1, 8'h40);
        repeat (2) @(posedge clk_sys);
        rdc(IX_CNT1_LO, 8'hFF);
        rdc(IX_CNT1_HI, 8'h0F);
        bus(IX_CSR0, 1'b0, 8'h00);
        tick;
        chk({7'h0, irq_o}, 8'h00);
        rdc(IX_CNT1_LO, r[7:0]);
        rdc(IX_CNT1_HI, {4'h0, r[11:8]});
        bus(IX_TCS2, 1'b0, 8'h00);
        chk(q & 8'h40, 8'h00);
        mask <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({7'h0, irq_o}, 8'h01);
        tick;
        chk({7'h0, irq_c}, 8'h01);
        rdc(IX_CSR0, 8'h01);
        rdc(IX_CSR0, 8'h00);
        chk({7'h0, irq_c}, 8'h00);
        rdc(IX_TCS, 8'h0F);
        rdc(IX_TCS, 8'h0B);
        chk({7'h0, irq_o}, 8'h00);
        halt <= 1'b1;
        tick;
        rdc(IX_CNT1_LO, r1[7:0]);
        halt <= 1'b0;
        tick;
        bus(IX_CNT1_LO, 1'b0, 8'h00);
        chk(q, r1[7:0] + 8'h01);
        // capture flag ignores writes and clears on a value read
        bus(IX_TCS, 1'b1, 8'h2B);
        @(posedge clk_sys);
        cap <= 1'b1;
        @(posedge clk_sys);
        cap <= 1'b0;
        bus(IX_TCS, 1'b1, 8'h2B);
        chk({6'h0, irq_c, irq_o}, 8'h02);
        rdc(IX_TCS, 8'h6B);
        rdc(IX_CAP_LO, r1[7:0] + 8'h01);
        rdc(IX_TCS, 8'h2B);
        bus(IX_PWM_OE, 1'b1, 8'hFF);
        rdc(IX_PWM_OE, 8'h55);
        chk({4'h0, oe}, 8'h0F);
        // every source and level; the unselected input is active whenever the selected one is not
        for (int k = 0; k < 4; k++) begin
            src = k[1];
            lvl = k[0];
            brk_in(src, ~lvl, lvl);
            bus(IX_BRK, 1'b1, {src, lvl, 2'b01, pat});
            rdc(IX_BRK, {src, lvl, 2'b01, pat});
            brk_in(src, lvl, ~lvl);
            repeat (3) @(posedge clk_sys);
            rdc(IX_BRK, {src, lvl, 2'b11, pat});
            chk({4'h0, pwm}, {4'h0, pat});
            brk_in(src, ~lvl, lvl);
            bus(IX_BRK, 1'b1, 8'h00);
            rdc(IX_BRK, 8'h00);
        end
        bus(IX_BRK, 1'b1, {4'h2, ~pat});
        rdc(IX_BRK, {4'h2, ~pat});
        chk({4'h0, pwm}, {4'h0, ~pat});
        bus(IX_PWM_OE, 1'b1, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk({oe, pwm}, 8'h00);
        // cpu clock runs for the three edges between two control writes
        bus(IX_TCS, 1'b1, 8'h03);
        bus(IX_TCS2, 1'b1, 8'h40);
        bus(IX_TCS, 1'b1, 8'h13);
        bus(IX_TCS, 1'b1, 8'h03);
        r1 = nxt(nxt(nxt(CNT_MAX, r), r), r);
        rdc(IX_CNT1_LO, r1[7:0]);
        rdc(IX_CNT1_HI, {4'h0, r1[11:8]});
        // counter two forced and enabled, then one fast tick for both
        bus(IX_TCS2, 1'b1, 8'h84);
        bus(IX_TCS, 1'b1, 8'h1B);
        @(posedge clk_sys);
        fast <= 1'b1;
        @(posedge clk_sys);
        fast <= 1'b0;
        r1 = nxt(r1, r);
        rdc(IX_CNT1_LO, r1[7:0]);
        rdc(IX_TCS2, 8'h0C);
        rdc(IX_CSR0 + 6'h03, 8'h01);
        // one-pulse on counter two: only the rising trigger edge restarts
        bus(IX_CSR0 + 6'h03, 1'b1, 8'h0C);
        trg(1'b1);
        rdc(IX_CSR0 + 6'h03, 8'h0D);
        trg(1'b0);
        rdc(IX_CSR0 + 6'h03, 8'h0C);
        test_done;
    end
endmodule
